// file: include/sdp_pkg.sv
// Shared types and constants for the SDRAM pin control block
`default_nettype none
package sdp_pkg;
  // ----------------------------------------
  // Widths and latencies
  // ----------------------------------------
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned LANE_W      = 8;
  localparam int unsigned LANES       = 2;
  localparam int unsigned ADDR_W      = 12;
  localparam int unsigned BANK_W      = 2;
  localparam int unsigned RD_MASK_LAT = 2;
  localparam int unsigned WR_MASK_LAT = 0;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic CKE_RST = 1'b1;

  // ----------------------------------------
  // Command codes: {row strobe, column strobe, write strobe}
  // ----------------------------------------
  typedef enum logic [2:0] {
    SDP_CMD_LOAD_MODE = 3'h0,
    SDP_CMD_REFRESH   = 3'h1,
    SDP_CMD_PRECHARGE = 3'h2,
    SDP_CMD_ACTIVE    = 3'h3,
    SDP_CMD_WRITE     = 3'h4,
    SDP_CMD_READ      = 3'h5,
    SDP_CMD_BURST_END = 3'h6,
    SDP_CMD_NOP       = 3'h7
  } sdp_cmd_t;

  // Gray codes along running -> power down -> suspend -> self refresh
  typedef enum logic [1:0] {
    SDP_RUN          = 2'h0,
    SDP_POWER_DOWN   = 2'h1,
    SDP_CLK_SUSPEND  = 2'h3,
    SDP_SELF_REFRESH = 2'h2
  } sdp_pwr_t;

  typedef struct packed {
    logic                valid;
    sdp_cmd_t            code;
    logic [BANK_W-1:0]   bank;
    logic [ADDR_W-1:0]   addr;
  } sdp_cmd_bus_t;

  localparam sdp_cmd_bus_t CMD_BUS_RST = '{valid: 1'b0, code: SDP_CMD_NOP, bank: '0, addr: '0};
endpackage : sdp_pkg
`default_nettype wire

// file: rtl/sdp_byte_lane.sv
// One byte lane of the data lines with its mask pipeline
`timescale 1ns/1ns
`default_nettype none
module sdp_byte_lane
  import sdp_pkg::*;
#(
  parameter int unsigned W   = LANE_W,
  parameter int unsigned LAT = RD_MASK_LAT
) (
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic         edge_ok,
  input  wire logic         mask,
  input  wire logic         rd_window,
  input  wire logic [W-1:0] rd_data,
  input  wire logic         wr_window,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_out,
  output logic              pin_oe,
  output logic      [W-1:0] wr_data,
  output logic              wr_en
);
  typedef struct packed {
    logic [LAT-1:0] mpipe;
    logic [W-1:0]   dout;
    logic           oe;
    logic [W-1:0]   wdat;
    logic           wen;
  } sdp_lane_t;

  sdp_lane_t s_q;
  sdp_lane_t s_d;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d     = s_q;
    s_d.wen = 1'b0;
    if (edge_ok) begin
      // Mask seen now drives the pins LAT edges later
      s_d.mpipe = {s_q.mpipe[LAT-2:0], mask};
      s_d.oe    = rd_window & ~s_q.mpipe[LAT-1];
      s_d.dout  = rd_data;
      // Write mask qualifies data of the same edge
      s_d.wen   = wr_window & ~mask;
      s_d.wdat  = pin_in;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pin_out = s_q.dout;
  assign pin_oe  = s_q.oe;
  assign wr_data = s_q.wdat;
  assign wr_en   = s_q.wen;
endmodule : sdp_byte_lane
`default_nettype wire

// file: rtl/sdp_pin_ctrl.sv
// Pin-side command, clock gating and byte lane control of the SDRAM
`timescale 1ns/1ns
`default_nettype none
module sdp_pin_ctrl
  import sdp_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              clk_gate,
  input  wire logic              chip_sel_n,
  input  wire logic              row_strobe_n,
  input  wire logic              col_strobe_n,
  input  wire logic              wr_strobe_n,
  input  wire logic [BANK_W-1:0] bank_sel,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              low_byte_mask,
  input  wire logic              high_byte_mask,
  input  wire logic [DATA_W-1:0] data_lines_in,
  output logic      [DATA_W-1:0] data_lines_out,
  output logic      [LANES-1:0]  data_lines_oe,
  output sdp_cmd_bus_t           cmd,
  output sdp_pwr_t               pwr_state,
  output logic                   edge_valid,
  input  wire logic              rd_window,
  input  wire logic [DATA_W-1:0] rd_data,
  input  wire logic              wr_window,
  output logic      [DATA_W-1:0] wr_data,
  output logic      [LANES-1:0]  wr_byte_en
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic         gate;
    sdp_pwr_t     pwr;
    sdp_cmd_bus_t cmd;
  } sdp_top_t;

  sdp_top_t s_q;
  sdp_top_t s_d;
  sdp_cmd_t strobe_code;
  logic     sel_refresh;
  logic     burst_busy;
  logic     gate_fall;

  // Strobes form one code together
  assign strobe_code = sdp_cmd_t'({row_strobe_n, col_strobe_n, wr_strobe_n});
  assign sel_refresh = ~chip_sel_n & (strobe_code == SDP_CMD_REFRESH);
  assign burst_busy  = rd_window | wr_window;
  // Gate read as a plain level; a synchroniser would move the edge it qualifies
  assign edge_valid  = clk_gate;
  assign gate_fall   = s_q.gate & ~clk_gate;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d           = s_q;
    s_d.gate      = clk_gate;
    s_d.cmd.valid = 1'b0;
    // Low power entered only on the falling gate edge
    unique case (s_q.pwr)
      SDP_RUN: begin
        if (gate_fall) begin
          if (sel_refresh) begin
            s_d.pwr = SDP_SELF_REFRESH;
          end else if (burst_busy) begin
            // Burst in flight is frozen, not dropped
            s_d.pwr = SDP_CLK_SUSPEND;
          end else begin
            s_d.pwr = SDP_POWER_DOWN;
          end
        end
      end
      SDP_POWER_DOWN, SDP_CLK_SUSPEND, SDP_SELF_REFRESH: begin
        // Wake-up edge only; no command is taken on it
        if (clk_gate) begin
          s_d.pwr = SDP_RUN;
        end
      end
    endcase
    // Deselect holds code, bank and address as they were; valid clears
    if (clk_gate && !chip_sel_n && s_q.pwr == SDP_RUN) begin
      s_d.cmd.valid = (strobe_code != SDP_CMD_NOP);
      s_d.cmd.code  = strobe_code;
      s_d.cmd.bank  = bank_sel;
      s_d.cmd.addr  = addr;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_q.gate <= CKE_RST;
      s_q.pwr  <= SDP_RUN;
      s_q.cmd  <= CMD_BUS_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign cmd       = s_q.cmd;
  assign pwr_state = s_q.pwr;

  // ----------------------------------------
  // Byte lanes
  // ----------------------------------------
  logic [LANES-1:0] lane_mask;
  assign lane_mask = {high_byte_mask, low_byte_mask};

  for (genvar g = 0; g < LANES; g++) begin : g_lane
    sdp_byte_lane #(
      .W   (LANE_W),
      .LAT (RD_MASK_LAT)
    ) u_lane (
      .mclk      (mclk),
      .reset     (reset),
      .edge_ok   (clk_gate),
      .mask      (lane_mask[g]),
      .rd_window (rd_window),
      .rd_data   (rd_data[g*LANE_W +: LANE_W]),
      .wr_window (wr_window),
      .pin_in    (data_lines_in[g*LANE_W +: LANE_W]),
      .pin_out   (data_lines_out[g*LANE_W +: LANE_W]),
      .pin_oe    (data_lines_oe[g]),
      .wr_data   (wr_data[g*LANE_W +: LANE_W]),
      .wr_en     (wr_byte_en[g])
    );
  end
endmodule : sdp_pin_ctrl
`default_nettype wire

// file: tb/sdp_pin_ctrl_monitor.sv
// Port checks for the SDRAM pin control block
`timescale 1ns/1ns
`default_nettype none
module sdp_pin_ctrl_monitor
  import sdp_pkg::*;
(
  input wire logic         mclk,
  input wire logic         reset,
  input wire logic         clk_gate,
  input wire logic         chip_sel_n,
  input wire logic         row_strobe_n,
  input wire logic         col_strobe_n,
  input wire logic         wr_strobe_n,
  input wire logic         low_byte_mask,
  input wire logic         high_byte_mask,
  input wire logic         rd_window,
  input wire logic         wr_window,
  input wire logic [1:0]   data_lines_oe,
  input wire logic [1:0]   wr_byte_en,
  input wire sdp_cmd_bus_t cmd,
  input wire sdp_pwr_t     pwr_state
);
  wire logic [2:0] code_in = {row_strobe_n, col_strobe_n, wr_strobe_n};
  wire logic [1:0] msk     = {high_byte_mask, low_byte_mask};
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  a_cmd_taken: assert property (clk_gate && !chip_sel_n && code_in != 3'h7 && pwr_state == SDP_RUN
    |=> cmd.valid && cmd.code == $past(code_in)) else $error("command lost");
  a_desel_quiet: assert property (chip_sel_n |=> !cmd.valid) else $error("deselected command");
  a_desel_hold: assert property (chip_sel_n |=> $stable(cmd.code)) else $error("code moved");
  a_gate_ignore: assert property (!clk_gate |=> !cmd.valid && wr_byte_en == 2'h0) else $error("bad edge used");
  a_wr_lanes: assert property (clk_gate && wr_window |=> wr_byte_en == ~$past(msk)) else $error("write mask");
  a_rd_lat: assert property (clk_gate ##1 clk_gate ##1 clk_gate && rd_window
    |=> data_lines_oe == ~$past(msk, 3)) else $error("read mask latency");
  a_rd_idle: assert property (clk_gate && !rd_window |=> data_lines_oe == 2'h0) else $error("stray drive");
  a_pwr_low: assert property (!clk_gate |=> pwr_state != SDP_RUN) else $error("gate low but running");
  a_pwr_run: assert property (clk_gate |=> pwr_state == SDP_RUN) else $error("gate high not running");
endmodule : sdp_pin_ctrl_monitor
bind sdp_pin_ctrl sdp_pin_ctrl_monitor i_sdp_pin_ctrl_monitor (.*);
`default_nettype wire

// file: tb/sdp_ctl_model.sv
// Controller model driving commands, masks and write data
`timescale 1ns/1ns
`default_nettype none
module sdp_ctl_model
  import sdp_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         run,
  output logic              chip_sel_n,
  output logic              row_strobe_n,
  output logic              col_strobe_n,
  output logic              wr_strobe_n,
  output logic              low_byte_mask,
  output logic              high_byte_mask,
  output logic [DATA_W-1:0] data_lines_in
);
  initial begin
    {chip_sel_n, row_strobe_n, col_strobe_n, wr_strobe_n} = 4'hF;
    {high_byte_mask, low_byte_mask} = 2'h3;
    data_lines_in = 16'h0000;
  end
  // Moves at the falling edge only, steady at the sampling edge
  always @(negedge mclk) begin
    if (run) begin
      chip_sel_n <= ($urandom % 4) == 0; // Idle cycles deselected
      {row_strobe_n, col_strobe_n, wr_strobe_n} <= 3'($urandom);
      {high_byte_mask, low_byte_mask} <= 2'($urandom); // Mask beside its beat
      data_lines_in <= ~data_lines_in ^ 16'($urandom);
    end
  end
endmodule : sdp_ctl_model
`default_nettype wire

// file: tb/tb_sdp_pin_ctrl.sv
// Self-checking bench for the SDRAM pin control block
`timescale 1ns/1ns
`default_nettype none
module tb_sdp_pin_ctrl
  import sdp_pkg::*;
;
  logic mclk, reset, clk_gate, run, rd_window, wr_window, edge_valid, g1;
  logic chip_sel_n, row_strobe_n, col_strobe_n, wr_strobe_n, low_byte_mask, high_byte_mask;
  logic [1:0]  data_lines_oe, wr_byte_en, m1, m2, lm;
  logic [15:0] data_lines_in, data_lines_out, rd_data, wr_data, km;
  logic [BANK_W-1:0] bank_sel;
  logic [ADDR_W-1:0] addr;
  sdp_cmd_bus_t cmd;
  sdp_pwr_t     pwr_state, exp_pwr;
  int err_count, samples_checked, cyc, gh;
  logic take;
  sdp_pin_ctrl i_sdp_pin_ctrl (.*);
  sdp_ctl_model i_sdp_ctl_model (.*);
  task automatic check(string name, logic [15:0] exp, logic [15:0] got);
    samples_checked++;
    if (exp !== got) begin
      err_count++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  endtask : check
  function automatic sdp_pwr_t next_pwr(sdp_pwr_t p, logic g, logic gp, logic sr, logic bw);
    if (g) return SDP_RUN;
    if (!gp) return p;
    if (sr) return SDP_SELF_REFRESH;
    if (bw) return SDP_CLK_SUSPEND;
    return SDP_POWER_DOWN;
  endfunction : next_pwr
  task automatic print_verdict();
    if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Hang guard, well above the planned run
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 5000) begin
      err_count++;
      print_verdict();
    end
  end
  // Compares before new stimulus lands, so inputs here are those just sampled
  always @(negedge mclk) begin
    if (reset) begin
      g1 <= 1'b1;
      gh <= 0;
      exp_pwr = SDP_RUN;
    end else begin
      take = clk_gate & g1 & ~chip_sel_n & ({row_strobe_n, col_strobe_n, wr_strobe_n} != 3'h7);
      check("valid", 16'(take), 16'(cmd.valid));
      if (take) check("code", 16'({row_strobe_n, col_strobe_n, wr_strobe_n}), 16'(cmd.code));
      if (take) check("bank", 16'(bank_sel), 16'(cmd.bank));
      if (take) check("addr", 16'(addr), 16'(cmd.addr));
      check("edge_valid", 16'(clk_gate), 16'(edge_valid));
      lm = {high_byte_mask, low_byte_mask};
      check("wr_en", 16'((clk_gate & wr_window) ? (lm ^ 2'h3) : 2'h0), 16'(wr_byte_en));
      if (clk_gate & wr_window) check("wr_data", data_lines_in, wr_data);
      km = {{8{~m2[1]}}, {8{~m2[0]}}};
      if (gh >= 2 && clk_gate) check("oe", 16'(rd_window ? (m2 ^ 2'h3) : 2'h0), 16'(data_lines_oe));
      if (gh >= 2 && clk_gate && rd_window) check("rd_out", rd_data & km, data_lines_out & km);
      exp_pwr = next_pwr(exp_pwr, clk_gate, g1, ~chip_sel_n & ({row_strobe_n, col_strobe_n, wr_strobe_n} == 3'h1),
                         rd_window | wr_window);
      check("pwr", 16'(exp_pwr), 16'(pwr_state));
      g1 <= clk_gate;
      gh <= clk_gate ? gh + 1 : 0;
    end
    if (clk_gate) begin
      m2 <= m1;
      m1 <= {high_byte_mask, low_byte_mask};
    end
  end
  initial begin
    {reset, clk_gate, run, rd_window, wr_window} = 5'h18;
    rd_data = 16'h0000;
    {bank_sel, addr} = '0;
    {err_count, samples_checked, cyc} = '0;
    repeat (3) @(negedge mclk);
    void'($urandom(32'h0CD05271));
    run <= 1'b1;
    for (int i = 0; i < 3000; i++) begin
      reset <= (i == 1500); // Second reset mid-run
      clk_gate <= (i % 700 > 690) ? 1'b0 : ($urandom % 8) != 0; // Long low stretch
      rd_window <= 1'($urandom);
      wr_window <= 1'($urandom);
      rd_data <= 16'($urandom);
      bank_sel <= BANK_W'($urandom);
      addr <= ADDR_W'($urandom);
      @(negedge mclk);
    end
    print_verdict();
  end
endmodule : tb_sdp_pin_ctrl
`default_nettype wire
